// ==== rtl/wdtu_pkg.sv ====
//------------------------------------------------------------
//------------------------------------------------------------
package wdtu_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int LFO_HZ = 31_000;
  localparam int TICK_DIV = CLK_HZ / LFO_HZ;
  localparam int CNT_W = 23;
  localparam int PS_W = 5;
  localparam logic [PS_W-1:0] PS_MAX = 5'h12;
  localparam logic [PS_W-1:0] PS_MIN = 5'h00;
  localparam logic [PS_W-1:0] PS_RESET = 5'h0b;
  localparam logic [PS_W:0] PS_BASE_SHIFT = 6'h05;
  localparam logic SWEN_RESET = 1'b0;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SW = 2'h1;
  localparam logic [1:0] MODE_AWAKE = 2'h2;
  localparam logic [1:0] MODE_ON = 2'h3;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADR_ISTS = 8'h04;
  localparam logic [ADDR_W-1:0] ADR_ICLR = 8'h08;
  localparam logic [ADDR_W-1:0] ADR_IEN = 8'h0c;
  localparam logic [ADDR_W-1:0] ADR_CNT = 8'h10;
  localparam int CTRL_SWEN_BIT = 0;
  localparam int CTRL_PS_LSB = 1;
  localparam int EV_W = 2;
  localparam int EV_AWAKE = 0;
  localparam int EV_SLEEP = 1;
endpackage

// ==== rtl/wdtu_tick_gen.sv ====
module wdtu_tick_gen #(
  parameter int DIV = wdtu_pkg::TICK_DIV
) (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic tick_o
);
  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  generate
    if (DIV < 2) begin : g_bad_div
      $error("tick divider must be at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } wdtu_tick_state_t;

  wdtu_tick_state_t st_r;
  wdtu_tick_state_t st_nxt;

  // free-running low-frequency time base; it divides the system clock clk_i, one tick every DIV cycles
  always_comb begin
    st_nxt.tick = (st_r.cnt == LAST);
    st_nxt.cnt = (st_r.cnt == LAST) ? '0 : st_r.cnt + W'(1);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_o = st_r.tick;

  a_tick_single: assert property (@(posedge clk_i) disable iff (rst_i)
    tick_o |=> !tick_o)
    else $error("tick lasted more than one cycle");
endmodule // wdtu_tick_gen

// ==== rtl/wdtu_top.sv ====
// Design decisions made here: the Wishbone register port and the placing of the registers.
module wdtu_top #(
  parameter int TICK_DIV = wdtu_pkg::TICK_DIV
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] watchdog_mode_config_i,
  input wire logic clear_watchdog_instruction_i,
  input wire logic sleep_i,
  input wire logic osc_fail_i,
  input wire logic oscillator_startup_timer_i,
  input wire logic crystal_clock_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [wdtu_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wdt_reset_o,
  output logic wake_o,
  output logic expiry_status_flag_o,
  output logic powerdown_status_flag_o,
  output logic irq_o
);
  //------------------------------------------------------------
  // state
  //------------------------------------------------------------
  typedef struct packed {
    logic [wdtu_pkg::PS_W-1:0] ps;
    logic swen;
    logic [wdtu_pkg::CNT_W-1:0] cnt;
    logic sleep_d;
    logic [wdtu_pkg::EV_W-1:0] ists;
    logic [wdtu_pkg::EV_W-1:0] ien;
    logic ack;
    logic [31:0] dat;
    logic rst_req;
    logic wake;
    logic expiry;
    logic powerdown;
    logic irq;
  } wdtu_state_t;

  localparam wdtu_state_t ST_RESET = '{
    ps: wdtu_pkg::PS_RESET,
    swen: wdtu_pkg::SWEN_RESET,
    default: '0
  };

  wdtu_state_t st_r;
  wdtu_state_t st_nxt;
  logic tick;
  logic active;
  logic clr;
  logic terminal;
  logic expire;
  logic sleep_entry;
  logic sleep_exit;
  logic [wdtu_pkg::PS_W-1:0] ps_eff;
  logic [wdtu_pkg::CNT_W-1:0] term_val;
  logic [wdtu_pkg::CNT_W:0] limit;
  logic wb_req;
  logic wr;
  logic [wdtu_pkg::EV_W-1:0] ev_set;
  logic [wdtu_pkg::EV_W-1:0] ev_clr;

  //------------------------------------------------------------
  // parameter checks
  //------------------------------------------------------------
  generate
    if (TICK_DIV < 2) begin : g_bad_tick_div
      $error("tick divider must be at least 2");
    end
    if (wdtu_pkg::CNT_W < int'(wdtu_pkg::PS_BASE_SHIFT) + int'(wdtu_pkg::PS_MAX)) begin : g_bad_cnt_w
      $error("count too narrow for the longest period");
    end
  endgenerate

  //------------------------------------------------------------
  // time base
  //------------------------------------------------------------
  wdtu_tick_gen #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  //------------------------------------------------------------
  // mode, period and clear decode
  //------------------------------------------------------------
  always_comb begin
    unique case (watchdog_mode_config_i)
      wdtu_pkg::MODE_ON: active = 1'b1;
      wdtu_pkg::MODE_AWAKE: active = !sleep_i;
      wdtu_pkg::MODE_SW: active = st_r.swen;
      wdtu_pkg::MODE_OFF: active = 1'b0;
    endcase
  end

  assign ps_eff = (st_r.ps > wdtu_pkg::PS_MAX) ? wdtu_pkg::PS_MIN : st_r.ps;
  assign limit = (wdtu_pkg::CNT_W + 1)'(1) << (wdtu_pkg::PS_BASE_SHIFT + {1'b0, ps_eff});
  assign term_val = wdtu_pkg::CNT_W'(limit - (wdtu_pkg::CNT_W + 1)'(1));
  assign sleep_entry = sleep_i && !st_r.sleep_d;
  assign sleep_exit = !sleep_i && st_r.sleep_d;
  assign clr = !active || clear_watchdog_instruction_i || osc_fail_i
    || sleep_entry
    || sleep_exit || (oscillator_startup_timer_i && crystal_clock_i);
  // at or past the end, so a period shortened mid-count still expires on the next tick
  assign terminal = (st_r.cnt >= term_val);
  assign expire = tick && active && !clr && terminal;
  assign ev_set[wdtu_pkg::EV_AWAKE] = expire && !sleep_i;
  assign ev_set[wdtu_pkg::EV_SLEEP] = expire && sleep_i;

  //------------------------------------------------------------
  // bus decode
  //------------------------------------------------------------
  assign wb_req = wb_cyc_i && wb_stb_i && !st_r.ack;
  assign wr = wb_req && wb_we_i;
  assign ev_clr = (wr && wb_adr_i == wdtu_pkg::ADR_ICLR && wb_sel_i[0]) ? wb_dat_i[wdtu_pkg::EV_W-1:0] : '0;

  //------------------------------------------------------------
  // next state
  //------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.sleep_d = sleep_i;
    if (clr || expire) begin
      st_nxt.cnt = '0;
    end else if (tick) begin
      st_nxt.cnt = st_r.cnt + wdtu_pkg::CNT_W'(1);
    end
    st_nxt.rst_req = ev_set[wdtu_pkg::EV_AWAKE];
    st_nxt.wake = ev_set[wdtu_pkg::EV_SLEEP];
    // expiry and power-down levels follow each sleep time-out until the core clears the watchdog
    if (ev_set[wdtu_pkg::EV_SLEEP]) begin
      st_nxt.expiry = 1'b1;
      st_nxt.powerdown = 1'b1;
    end else if (clear_watchdog_instruction_i) begin
      st_nxt.expiry = 1'b0;
      st_nxt.powerdown = 1'b0;
    end
    st_nxt.ists = (st_r.ists & ~ev_clr) | ev_set;
    st_nxt.ack = wb_req;
    st_nxt.dat = '0;
    if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        wdtu_pkg::ADR_CTRL: st_nxt.dat = 32'({st_r.ps, st_r.swen});
        wdtu_pkg::ADR_ISTS: st_nxt.dat = 32'(st_r.ists);
        wdtu_pkg::ADR_IEN: st_nxt.dat = 32'(st_r.ien);
        wdtu_pkg::ADR_CNT: st_nxt.dat = 32'(st_r.cnt);
        default: st_nxt.dat = '0;
      endcase
    end
    if (wr && wb_sel_i[0]) begin
      if (wb_adr_i == wdtu_pkg::ADR_CTRL) begin
        st_nxt.swen = wb_dat_i[wdtu_pkg::CTRL_SWEN_BIT];
        st_nxt.ps = wb_dat_i[wdtu_pkg::CTRL_PS_LSB +: wdtu_pkg::PS_W];
      end
      if (wb_adr_i == wdtu_pkg::ADR_IEN) begin
        st_nxt.ien = wb_dat_i[wdtu_pkg::EV_W-1:0];
      end
    end
    st_nxt.irq = |(st_nxt.ists & st_nxt.ien);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_o = st_r.dat;
  assign wb_ack_o = st_r.ack;
  assign wdt_reset_o = st_r.rst_req;
  assign wake_o = st_r.wake;
  assign expiry_status_flag_o = st_r.expiry;
  assign powerdown_status_flag_o = st_r.powerdown;
  assign irq_o = st_r.irq;

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  a_awake_expiry_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick && active && !clr && terminal && !sleep_i) |=> (wdt_reset_o && !wake_o && st_r.cnt == '0))
    else $error("awake expiry gave no reset");

  a_sleep_expiry_wake: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick && active && !clr && terminal && sleep_i) |=> (wake_o && !wdt_reset_o && expiry_status_flag_o))
    else $error("sleep expiry did not wake");

  a_always_on_counts: assert property (@(posedge clk_i) disable iff (rst_i)
    (watchdog_mode_config_i == wdtu_pkg::MODE_ON && tick && !clr && !terminal)
    |=> st_r.cnt == $past(st_r.cnt) + wdtu_pkg::CNT_W'(1))
    else $error("always-on mode did not count");

  a_awake_mode_sleep: assert property (@(posedge clk_i) disable iff (rst_i)
    (watchdog_mode_config_i == wdtu_pkg::MODE_AWAKE && sleep_i) |=> st_r.cnt == '0)
    else $error("awake-only mode counted in sleep");

  a_sw_mode_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    (watchdog_mode_config_i == wdtu_pkg::MODE_SW && !st_r.swen) |=> st_r.cnt == '0)
    else $error("software mode counted while disabled");

  a_off_mode_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    (watchdog_mode_config_i == wdtu_pkg::MODE_OFF) |=> (st_r.cnt == '0 && !wdt_reset_o))
    else $error("off mode counted");

  a_period_terminal: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r.ps == wdtu_pkg::PS_MAX) |-> term_val == 23'h7fffff)
    else $error("longest period terminal wrong");

  a_reserved_minimum: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r.ps > wdtu_pkg::PS_MAX || st_r.ps == wdtu_pkg::PS_MIN) |-> term_val == 23'h00001f)
    else $error("reserved period not minimum");

  a_reset_period: assert property (@(posedge clk_i)
    $fell(rst_i) |-> (st_r.ps == wdtu_pkg::PS_RESET && term_val == 23'h00ffff))
    else $error("period default wrong after reset");

  a_clear_cmd: assert property (@(posedge clk_i) disable iff (rst_i)
    (clear_watchdog_instruction_i || osc_fail_i) |=> st_r.cnt == '0)
    else $error("clear event did not clear count");

  a_sleep_entry_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (sleep_i && !st_r.sleep_d) |=> st_r.cnt == '0)
    else $error("sleep entry did not clear");

  a_ost_hold_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (oscillator_startup_timer_i && crystal_clock_i) [*2] |=> st_r.cnt == '0)
    else $error("count moved during start-up hold");

  a_bus_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack timing wrong");

  a_sleep_exit_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (!sleep_i && st_r.sleep_d) |=> st_r.cnt == '0)
    else $error("sleep exit did not clear");

  a_no_tick_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (!tick && !clr) |=> $stable(st_r.cnt))
    else $error("count moved without a tick");

  a_expire_needs_tick: assert property (@(posedge clk_i) disable iff (rst_i)
    (wdt_reset_o || wake_o) |-> $past(tick))
    else $error("time-out not on a tick");

  a_awake_mode_runs: assert property (@(posedge clk_i) disable iff (rst_i)
    (watchdog_mode_config_i == wdtu_pkg::MODE_AWAKE && !sleep_i && tick && !clr && !terminal)
    |=> st_r.cnt == $past(st_r.cnt) + wdtu_pkg::CNT_W'(1))
    else $error("awake-only mode did not count");

  a_sw_mode_runs: assert property (@(posedge clk_i) disable iff (rst_i)
    (watchdog_mode_config_i == wdtu_pkg::MODE_SW && st_r.swen && tick && !clr && !terminal)
    |=> st_r.cnt == $past(st_r.cnt) + wdtu_pkg::CNT_W'(1))
    else $error("software mode did not count");

  a_clear_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    clear_watchdog_instruction_i |=> (!wdt_reset_o && !wake_o))
    else $error("time-out despite clear");

  a_reset_only_awake: assert property (@(posedge clk_i) disable iff (rst_i)
    sleep_i |=> !wdt_reset_o)
    else $error("reset raised in sleep");

  a_wake_only_asleep: assert property (@(posedge clk_i) disable iff (rst_i)
    !sleep_i |=> !wake_o)
    else $error("wake raised while awake");

  a_reset_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wdt_reset_o |=> !wdt_reset_o)
    else $error("reset request longer than one cycle");

  a_wake_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wake_o |=> !wake_o)
    else $error("wake longer than one cycle");

  a_flags_cleared: assert property (@(posedge clk_i) disable iff (rst_i)
    (clear_watchdog_instruction_i && !ev_set[wdtu_pkg::EV_SLEEP])
    |=> (!expiry_status_flag_o && !powerdown_status_flag_o))
    else $error("status flags not cleared");

  a_flag_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (expiry_status_flag_o && !clear_watchdog_instruction_i) |=> expiry_status_flag_o)
    else $error("expiry flag dropped on its own");

  a_status_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    (ev_clr == '0) |=> (st_r.ists & $past(st_r.ists)) == $past(st_r.ists))
    else $error("status bit fell without a clear");

  a_status_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    (ev_set != '0) |=> (st_r.ists & $past(ev_set)) == $past(ev_set))
    else $error("status event lost");

  a_read_idle_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> wb_dat_o == '0)
    else $error("read data outside ack");

  a_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without a request");
endmodule // wdtu_top

// ==== testbench/wdtu_core_model.sv ====
module wdtu_core_model #(
  parameter int PERIOD = 20
) (
  input wire logic clk_i,
  input wire logic en_i,
  output logic clear_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // one clear pulse every PERIOD cycles while running
  always @(posedge clk_i) begin
    cnt <= (en_i && cnt < PERIOD - 1) ? cnt + 1 : 0;
    clear_o <= en_i && cnt == PERIOD - 1;
  end
endmodule // wdtu_core_model

// ==== testbench/wdtu_top_test.sv ====
module wdtu_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] mode = 2'h3;
  logic sleep = 1'b0, osc_fail = 1'b0, oscillator_startup_timer = 1'b0, xtal = 1'b0, core_en = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, dat;
  logic clr, ack, wrst, wake, exp_f, pd_f, irq;
  int err_count = 0;
  int samples_checked = 0;
  int c;
  int ps_tab[5] = '{0, 1, 2, 19, 31};
  int per_tab[5] = '{64, 128, 256, 64, 64};
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  wdtu_top #(.TICK_DIV(2)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .watchdog_mode_config_i(mode),
    .clear_watchdog_instruction_i(clr), .sleep_i(sleep), .osc_fail_i(osc_fail),
    .oscillator_startup_timer_i(oscillator_startup_timer), .crystal_clock_i(xtal), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wdt_reset_o(wrst), .wake_o(wake), .expiry_status_flag_o(exp_f), .powerdown_status_flag_o(pd_f),
    .irq_o(irq));
  wdtu_core_model #(.PERIOD(20)) u_core (.clk_i(clk_i), .en_i(core_en), .clear_o(clr));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    dat = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task wait_ev(input logic sel_wake, output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((sel_wake ? wake : wrst) !== 1'b1 && n < 2000);
  endtask
  task quiet(input string name);
    int bad;
    bad = 0;
    repeat (150) begin
      @(posedge clk_i);
      if (wrst !== 1'b0 || wake !== 1'b0) bad++;
    end
    check(name, 32'h0, bad);
  endtask
  task set_ps(input logic [4:0] ps, input logic swen, input logic [1:0] m);
    mode <= 2'h0;
    wb(1'b1, wdtu_pkg::ADR_CTRL, {26'h0, ps, swen});
    mode <= m;
  endtask
  task test_done;
    $display("checks %0d, errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    // the tests need about 3000 cycles; give up after 20000
    #200000;
    err_count++;
    test_done();
  end
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, wdtu_pkg::ADR_CTRL, 32'h0);
    check("ctrl reset", 32'h16, dat);
    wb(1'b0, 8'h14, 32'h0);
    check("unmapped", 32'h0, dat);
    wb(1'b1, wdtu_pkg::ADR_IEN, 32'h1);
    for (int i = 0; i < 5; i++) begin
      set_ps(ps_tab[i][4:0], 1'b0, 2'h3);
      wait_ev(1'b0, c);
      wait_ev(1'b0, c);
      check("period", per_tab[i], c);
    end
    set_ps(5'h01, 1'b0, 2'h3);
    repeat (100) @(posedge clk_i);
    wb(1'b1, wdtu_pkg::ADR_CTRL, 32'h0);
    wait_ev(1'b0, c);
    check("shortened period", 32'h1, c < 10);
    mode <= 2'h0;
    wb(1'b0, wdtu_pkg::ADR_ISTS, 32'h0);
    check("status", 32'h1, dat);
    check("irq set", 32'h1, irq);
    wb(1'b1, wdtu_pkg::ADR_IEN, 32'h0);
    repeat (2) @(posedge clk_i);
    check("irq masked", 32'h0, irq);
    wb(1'b1, wdtu_pkg::ADR_ICLR, 32'h1);
    wb(1'b0, wdtu_pkg::ADR_ISTS, 32'h0);
    check("status clr", 32'h0, dat);
    quiet("mode off");
    set_ps(5'h1f, 1'b0, 2'h1);
    quiet("sw off");
    wb(1'b1, wdtu_pkg::ADR_CTRL, {26'h0, 5'h1f, 1'b1});
    wait_ev(1'b0, c);
    check("sw on", 32'h1, c < 100);
    mode <= 2'h3;
    core_en <= 1'b1;
    quiet("core clears");
    core_en <= 1'b0;
    osc_fail <= 1'b1;
    quiet("osc fail");
    osc_fail <= 1'b0;
    xtal <= 1'b1;
    oscillator_startup_timer <= 1'b1;
    quiet("startup hold");
    oscillator_startup_timer <= 1'b0;
    mode <= 2'h2;
    sleep <= 1'b1;
    quiet("off in sleep");
    mode <= 2'h3;
    wait_ev(1'b1, c);
    check("sleep wake", 32'h1, c < 100);
    wb(1'b0, wdtu_pkg::ADR_ISTS, 32'h0);
    check("sleep status", 32'h1, dat[1]);
    check("expiry flag", 32'h1, exp_f);
    check("powerdown flag", 32'h1, pd_f);
    sleep <= 1'b0;
    mode <= 2'h0;
    core_en <= 1'b1;
    repeat (25) @(posedge clk_i);
    check("expiry cleared", 32'h0, exp_f);
    test_done();
  end
endmodule // wdtu_top_test
